// File: include/sla_pkg.sv
package sla_pkg;

    // ------------------------------------------------------------
    // Register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] DUR_OFS = 8'h10;
    localparam logic [7:0] RST_OFS = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_LONG_BIT = 0;
    localparam int CTRL_ALM_POL_BIT = 1;
    localparam int CTRL_WRN_POL_BIT = 2;
    localparam int CTRL_REM_POL_BIT = 3;
    localparam int CTRL_WIDTH = 4;
    localparam logic [3:0] CTRL_RST_VAL = 4'h0;

    // Reset command register: writing a one counts as one reset push
    localparam int RST_PUSH_BIT = 0;

    // ------------------------------------------------------------
    // Interrupt fields
    // ------------------------------------------------------------
    localparam int IRQ_LOSS_BIT = 0;
    localparam int IRQ_LONG_BIT = 1;
    localparam int IRQ_PRESS_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SHORT_THR_S = 1;
    localparam int LONG_THR_S = 2;
    localparam int SHORT_THR_CYC = SHORT_THR_S * CLK_HZ;
    localparam int LONG_THR_CYC = LONG_THR_S * CLK_HZ;
    localparam int DUR_WIDTH = 32;

    // ------------------------------------------------------------
    // Supervisor states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SLA_RUN = 3'b000,
        SLA_OUTAGE = 3'b001,
        SLA_ALM_BUZZ = 3'b010,
        SLA_ALM_HOLD = 3'b011
    } sla_state_t;

    // Logical (unpolarised) contact outputs
    typedef struct packed {
        logic alarm;
        logic warning;
        logic remote;
        logic buzzer;
        logic brake;
    } sla_outs_t;

endpackage

// File: rtl/sla_sync.sv
`timescale 1ns/100ps
// Two flop synchroniser for one level
module sla_sync #(
    parameter logic RST_VAL = 1'b0 // Level held in reset, match the pin's idle level
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic d_i, // Async level
    output logic q_o // Synced level
);
    logic meta_ff;
    logic sync_ff;

    // First stage read only by second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule // sla_sync

// File: rtl/sla_top.sv
`timescale 1ns/100ps
module sla_top #(
    parameter int unsigned SHORT_CYC = sla_pkg::SHORT_THR_CYC, // 1 s in cycles
    parameter int unsigned LONG_CYC = sla_pkg::LONG_THR_CYC // 2 s in cycles
) (
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_i, // Sync reset, high
    input wire logic supply_ok_i, // Mains present, async
    input wire logic press_rise_i, // Rapid pressure rise, async
    input wire logic warn_event_i, // Warning condition, same clock
    input wire logic remote_mode_i, // Remote mode request, same clock
    input wire logic [31:0] wb_adr_i, // Wishbone address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic wb_we_i, // Wishbone write
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone ack
    output logic alarm_o, // Alarm contact, polarised
    output logic warning_o, // Warning contact, polarised
    output logic remote_o, // Remote contact, polarised
    output logic buzzer_o, // Buzzer drive
    output logic brake_o, // Motor brake request
    output logic irq_o // Interrupt, level high
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic supply_s;
    logic press_s;

    // Resets to supply present so release gives no false loss edge
    sla_sync #(
        .RST_VAL(1'b1)
    ) u_sync_supply (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(supply_ok_i),
        .q_o(supply_s)
    );

    sla_sync u_sync_press (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(press_rise_i),
        .q_o(press_s)
    );

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [3:0] ctrl_ff, nxt_ctrl;
    logic [2:0] imask_ff, nxt_imask;
    logic [2:0] istat_ff, nxt_istat;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [31:0] dur_ff, nxt_dur;
    logic [31:0] last_dur_ff, nxt_last_dur;
    logic supply_d_ff, press_d_ff;
    sla_pkg::sla_state_t state_ff, nxt_state;
    sla_pkg::sla_outs_t outs_ff, nxt_outs;
    logic [4:0] pins_ff, nxt_pins;
    logic irq_ff, nxt_irq;

    logic bus_req;
    logic wr_lo;
    logic [7:0] adr;
    logic reset_push;
    logic loss_evt, restore_evt, press_evt, long_evt;
    logic [31:0] thr;

    assign adr = wb_adr_i[7:0];
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lo = bus_req && wb_we_i && wb_sel_i[0];
    assign reset_push = wr_lo && (adr == sla_pkg::RST_OFS) && wb_dat_i[sla_pkg::RST_PUSH_BIT];

    // Threshold choice; defaults to 1 s
    assign thr = ctrl_ff[sla_pkg::CTRL_LONG_BIT] ? LONG_CYC : SHORT_CYC;

    // Edge events on synced levels
    assign loss_evt = supply_d_ff && !supply_s;
    assign restore_evt = !supply_d_ff && supply_s;
    assign press_evt = press_s && !press_d_ff;
    assign long_evt = restore_evt && (dur_ff > thr);

    // Register writes, read mux, one cycle ack
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_ack = bus_req;
        nxt_rdat = 32'h0000_0000;
        if (wr_lo && adr == sla_pkg::CTRL_OFS) begin
            nxt_ctrl = wb_dat_i[3:0];
        end
        if (wr_lo && adr == sla_pkg::IRQ_MASK_OFS) begin
            nxt_imask = wb_dat_i[2:0];
        end
        if (bus_req && !wb_we_i) begin
            unique case (adr)
                sla_pkg::CTRL_OFS: nxt_rdat = {28'h000_0000, ctrl_ff};
                sla_pkg::STAT_OFS: nxt_rdat = {24'h00_0000, state_ff, outs_ff};
                sla_pkg::IRQ_STAT_OFS: nxt_rdat = {29'h0000_0000, istat_ff};
                sla_pkg::IRQ_MASK_OFS: nxt_rdat = {29'h0000_0000, imask_ff};
                sla_pkg::DUR_OFS: nxt_rdat = last_dur_ff;
                default: nxt_rdat = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Sticky status: set wins over write-one clear
    always_comb begin
        nxt_istat = istat_ff;
        if (wr_lo && adr == sla_pkg::IRQ_STAT_OFS) begin
            nxt_istat = istat_ff & ~wb_dat_i[2:0];
        end
        nxt_istat[sla_pkg::IRQ_LOSS_BIT] = nxt_istat[sla_pkg::IRQ_LOSS_BIT] | loss_evt;
        nxt_istat[sla_pkg::IRQ_LONG_BIT] = nxt_istat[sla_pkg::IRQ_LONG_BIT] | long_evt;
        nxt_istat[sla_pkg::IRQ_PRESS_BIT] = nxt_istat[sla_pkg::IRQ_PRESS_BIT] | press_evt;
        nxt_irq = |(nxt_istat & nxt_imask);
    end

    // ------------------------------------------------------------
    // Outage timer
    // ------------------------------------------------------------
    // Saturating so a very long outage never wraps to short
    always_comb begin
        nxt_dur = dur_ff;
        nxt_last_dur = last_dur_ff;
        if (loss_evt) begin
            nxt_dur = 32'h0000_0000;
        end else if (!supply_s && dur_ff != 32'hFFFF_FFFF) begin
            nxt_dur = dur_ff + 32'h0000_0001;
        end
        if (restore_evt) begin
            nxt_last_dur = dur_ff;
        end
    end

    // ------------------------------------------------------------
    // Supervisor and contacts
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_outs = outs_ff;
        unique case (state_ff)
            sla_pkg::SLA_RUN: begin
                nxt_outs.warning = warn_event_i;
                nxt_outs.remote = remote_mode_i;
                if (loss_evt) begin
                    nxt_state = sla_pkg::SLA_OUTAGE;
                end
            end
            sla_pkg::SLA_OUTAGE: begin
                // Contacts frozen while the length is unknown, except alarm and brake, which a pressure rise still sets
                if (dur_ff > thr) begin
                    nxt_outs.alarm = 1'b1;
                    nxt_outs.buzzer = 1'b1;
                    nxt_outs.remote = 1'b0;
                    nxt_state = sla_pkg::SLA_ALM_BUZZ;
                end else if (restore_evt) begin
                    nxt_state = sla_pkg::SLA_RUN;
                end
            end
            sla_pkg::SLA_ALM_BUZZ: begin
                // Warning keeps its state until a reset
                if (reset_push) begin
                    nxt_outs.buzzer = 1'b0;
                    nxt_outs.warning = 1'b0;
                    nxt_state = sla_pkg::SLA_ALM_HOLD;
                end
            end
            sla_pkg::SLA_ALM_HOLD: begin
                // Second push only counts with supply back
                if (reset_push && supply_s) begin
                    nxt_outs.alarm = 1'b0;
                    nxt_outs.brake = 1'b0;
                    nxt_state = sla_pkg::SLA_RUN;
                end
            end
            default: begin
                nxt_state = sla_pkg::SLA_RUN;
            end
        endcase
        if (press_evt) begin
            nxt_outs.brake = 1'b1;
            nxt_outs.alarm = 1'b1;
        end else if (reset_push && state_ff == sla_pkg::SLA_RUN) begin
            nxt_outs.brake = 1'b0;
            nxt_outs.alarm = 1'b0;
        end
    end

    // Output polarity applied in the registered pin stage
    always_comb begin
        nxt_pins[4] = nxt_outs.alarm ^ ctrl_ff[sla_pkg::CTRL_ALM_POL_BIT];
        nxt_pins[3] = nxt_outs.warning ^ ctrl_ff[sla_pkg::CTRL_WRN_POL_BIT];
        nxt_pins[2] = nxt_outs.remote ^ ctrl_ff[sla_pkg::CTRL_REM_POL_BIT];
        nxt_pins[1] = nxt_outs.buzzer;
        nxt_pins[0] = nxt_outs.brake;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= sla_pkg::CTRL_RST_VAL;
            imask_ff <= 3'h0;
            istat_ff <= 3'h0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            dur_ff <= 32'h0000_0000;
            last_dur_ff <= 32'h0000_0000;
            supply_d_ff <= 1'b1;
            press_d_ff <= 1'b0;
            state_ff <= sla_pkg::SLA_RUN;
            outs_ff <= '0;
            pins_ff <= 5'h00;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            imask_ff <= nxt_imask;
            istat_ff <= nxt_istat;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            dur_ff <= nxt_dur;
            last_dur_ff <= nxt_last_dur;
            supply_d_ff <= supply_s;
            press_d_ff <= press_s;
            state_ff <= nxt_state;
            outs_ff <= nxt_outs;
            pins_ff <= nxt_pins;
            irq_ff <= nxt_irq;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign alarm_o = pins_ff[4];
    assign warning_o = pins_ff[3];
    assign remote_o = pins_ff[2];
    assign buzzer_o = pins_ff[1];
    assign brake_o = pins_ff[0];
    assign irq_o = irq_ff;

endmodule // sla_top

// File: tb/sla_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module sla_checker #(
    parameter int unsigned SHORT_CYC = 100 // Short threshold
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic supply_ok_i, // Mains
    input wire logic press_rise_i, // Pressure rise
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic wb_ack_o, // Ack
    input wire logic alarm_o, // Alarm pin
    input wire logic warning_o, // Warning pin
    input wire logic buzzer_o, // Buzzer
    input wire logic brake_o // Brake
);
    logic [3:0] wr_age_ff, nxt_wr_age;
    logic [3:0] ev_age_ff, nxt_ev_age;
    logic [31:0] low_ff, nxt_low;
    // Ages saturate so they never wrap back into range
    always_comb begin
        nxt_wr_age = wr_age_ff + {3'h0, wr_age_ff != 4'hF};
        nxt_ev_age = ev_age_ff + {3'h0, ev_age_ff != 4'hF};
        nxt_low = supply_ok_i ? 32'h0 : low_ff + 32'h1;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) nxt_wr_age = 4'h0;
        if (!supply_ok_i || press_rise_i) nxt_ev_age = 4'h0;
    end
    always_ff @(posedge clk_i) begin
        wr_age_ff <= rst_i ? 4'hF : nxt_wr_age;
        ev_age_ff <= rst_i ? 4'hF : nxt_ev_age;
        low_ff <= rst_i ? 32'h0 : nxt_low;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_quiet_out;
        (!supply_ok_i && !wb_cyc_i) [*6];
    endsequence
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_RESET_QUIET:
        assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !buzzer_o && !brake_o)
        else $error("outputs active in reset");
    AST_BRAKE_ON:
        assert property ($rose(press_rise_i) && supply_ok_i |-> ##[1:8] brake_o)
        else $error("no brake on pressure rise");
    AST_OUTAGE_FREEZE:
        assert property (s_quiet_out |-> $stable(warning_o)) else $error("warning moved");
    AST_BUZZ_LATE:
        assert property ($rose(buzzer_o) && !supply_ok_i |-> low_ff > SHORT_CYC)
        else $error("buzzer before threshold");
    AST_BUZZ_RESET:
        assert property ($fell(buzzer_o) |-> wr_age_ff < 4'h6) else $error("buzzer fell alone");
    AST_ALARM_CAUSE:
        assert property ($changed(alarm_o) |-> wr_age_ff < 4'h6 || ev_age_ff < 4'h8)
        else $error("alarm moved without cause");
endmodule // sla_checker

bind sla_top sla_checker #(.SHORT_CYC(SHORT_CYC)) u_sla_checker (
    .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i), .press_rise_i(press_rise_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .alarm_o(alarm_o), .warning_o(warning_o), .buzzer_o(buzzer_o), .brake_o(brake_o));

// File: tb/sla_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host reading the relay contacts
// ----------------------------------------
module sla_host (
    input wire logic clk_i, // Clock
    input wire logic [2:0] pol_i, // Alarm, warning, remote polarity
    input wire logic alarm_i, // Alarm contact
    input wire logic warning_i, // Warning contact
    input wire logic remote_i, // Remote contact
    input wire logic buzzer_i, // Buzzer
    input wire logic brake_i, // Brake request
    output sla_pkg::sla_outs_t seen_o // Decoded contacts
);
    sla_pkg::sla_outs_t nxt_seen;
    // Undo the signal mode so the bench compares logical states
    always_comb begin
        nxt_seen = {alarm_i ^ pol_i[2], warning_i ^ pol_i[1], remote_i ^ pol_i[0],
            buzzer_i, brake_i};
    end
    always_ff @(posedge clk_i) begin
        seen_o <= nxt_seen;
    end
endmodule // sla_host

// File: tb/test_sla_top.sv
`timescale 1ns/100ps
module test_sla_top;
    localparam int SC = 100; // Shortened 1 s
    localparam int LC = 200; // Shortened 2 s
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q;
        logic [2:0] p;} sla_row_t;
    sla_row_t rows[6] = '{'{0, sla_pkg::CTRL_OFS, 0, 0, 0}, '{0, sla_pkg::STAT_OFS, 0, 0, 0},
        '{1, 8'h40, 32'hFFFFFFFF, 0, 0}, '{0, 8'h40, 0, 0, 0},
        '{1, sla_pkg::CTRL_OFS, 32'hE, 0, 7}, '{1, sla_pkg::CTRL_OFS, 0, 0, 0}};
    logic clk_i = 0, rst_i = 1, sup = 1, prs = 0, wrn = 0, rmt = 0, we = 0, cyc = 0, stb = 0;
    logic [31:0] adr = 0, dat = 0, rd, rdat;
    logic ack, alm, wpin, rem, buz, brk, irq, ia;
    sla_pkg::sla_outs_t seen;
    int n_errors = 0, tests_run = 0;
    always #50 clk_i = ~clk_i;
    sla_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .supply_ok_i(sup), .press_rise_i(prs), .warn_event_i(wrn), .remote_mode_i(rmt),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .alarm_o(alm), .warning_o(wpin),
        .remote_o(rem), .buzzer_o(buz), .brake_o(brk), .irq_o(irq));
    sla_host u_host (.clk_i(clk_i), .pol_i(3'h0), .alarm_i(alm), .warning_i(wpin),
        .remote_i(rem), .buzzer_i(buz), .brake_i(brk), .seen_o(seen));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Single classic cycle, released only after ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {24'h0, a};
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic push;
        wb(1, sla_pkg::RST_OFS, 1);
        wait_n(6);
    endtask
    task automatic results;
        $display("Checks run %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard, well beyond the expected run
    initial begin
        #(100 * 20000);
        n_errors++;
        results;
    end
    initial begin
        wait_n(3);
        rst_i <= 0;
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("read", rows[i].q, rd);
            wait_n(4);
            chk("pins", {29'h0, rows[i].p}, {29'h0, alm, wpin, rem});
        end
        wrn <= 1;
        rmt <= 1;
        wait_n(6);
        sup <= 0;
        wait_n(SC - 10);
        sup <= 1;
        wait_n(8);
        chk("short", 32'h0C, {27'h0, seen});
        wb(0, sla_pkg::DUR_OFS, 0);
        chk("dur", 1, 32'(rd + 13 > SC && rd < SC - 7));
        wb(1, sla_pkg::CTRL_OFS, 1);
        sup <= 0;
        wait_n(LC - 50);
        sup <= 1;
        wait_n(8);
        chk("option", 32'h0C, {27'h0, seen});
        // Over the long threshold: alarm during and after
        sup <= 0;
        wait_n(LC + 20);
        chk("during", 32'h1A, {27'h0, seen});
        sup <= 1;
        wait_n(8);
        // Remote contact stays open until the alarm is cleared
        chk("after", 32'h1A, {27'h0, seen});
        push;
        chk("first", 32'h4, {29'h0, seen.alarm, seen.warning, seen.buzzer});
        push;
        chk("second", 32'h0, {30'h0, seen.alarm, seen.buzzer});
        wb(0, sla_pkg::IRQ_STAT_OFS, 0);
        chk("irq stat", 32'h3, rd & 32'h3);
        wb(1, sla_pkg::IRQ_MASK_OFS, 0);
        ia = irq;
        wb(1, sla_pkg::IRQ_MASK_OFS, 32'h7);
        chk("irq masked", 0, {31'h0, ia});
        chk("irq mask", 1, {31'h0, irq});
        wb(1, sla_pkg::IRQ_STAT_OFS, 32'h7);
        wb(0, sla_pkg::IRQ_STAT_OFS, 0);
        chk("irq clear", 0, rd);
        chk("irq pin clear", 0, {31'h0, irq});
        prs <= 1;
        wait_n(8);
        chk("press", 32'h3, {30'h0, seen.alarm, seen.brake});
        chk("press irq", 1, {31'h0, irq});
        prs <= 0;
        push;
        chk("press off", 32'h0, {30'h0, seen.alarm, seen.brake});
        // Mid-run reset; supply stays high so no loss may be logged after it
        rst_i <= 1;
        wait_n(3);
        chk("reset pins", 0, {26'h0, alm, wpin, rem, buz, brk, irq});
        rst_i <= 0;
        wb(0, sla_pkg::IRQ_STAT_OFS, 0);
        chk("reset irq", 0, rd);
        wb(0, sla_pkg::CTRL_OFS, 0);
        chk("reset ctrl", 0, rd);
        results;
    end
endmodule // test_sla_top
